// ==== core/conversion_timer.v ====
// Conversion period timer: a 125 ms prescaler feeding a tick counter.
// Assumes one clock; sleep holds it cleared.
`timescale 1ns/10ps
`default_nettype none
`include "temp_sensor_defs.vh"

module conversion_timer #(
	parameter [31:0] TICK_CYCLES = `RATE_BASE_MS * 1000 * `CLK_MHZ
) (
	input wire core_clk,
	input wire rst_n,
	input wire hold,
	input wire [5:0] period_ticks,
	output wire period_due
);

	reg [31:0] pre_reg;
	reg [5:0] tick_reg;
	wire tick_en;

	// Prescaler gives one enable pulse every base period
	assign tick_en = (pre_reg == TICK_CYCLES - 32'h0000_0001);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= 32'h0000_0000;
		end else if (hold || tick_en) begin
			pre_reg <= 32'h0000_0000;
		end else begin
			pre_reg <= pre_reg + 32'h0000_0001;
		end
	end

	// Ticks counted up to the selected period; a rate change applies from the next tick
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_reg <= 6'h00;
		end else if (hold || period_due) begin
			tick_reg <= 6'h00;
		end else if (tick_en) begin
			tick_reg <= tick_reg + 6'h01;
		end
	end

	assign period_due = tick_en && (tick_reg + 6'h01 >= period_ticks);

endmodule
`default_nettype wire

// ==== core/temp_sensor_defs.vh ====
// Constants of the temperature sensor register bank: offsets, fields,
// reset values and conversion timing.
// Assumes a 200 MHz core clock.
`ifndef TEMP_SENSOR_DEFS_VH
`define TEMP_SENSOR_DEFS_VH

// Pointer selectors
`define SEL_RESULT 2'h0
`define SEL_SETUP 2'h1
`define SEL_LOWER 2'h2
`define SEL_UPPER 2'h3

// Setup register field positions
`define SETUP_WIDTH_BIT 4
`define SETUP_FLAG_BIT 5
`define SETUP_RATE_LO 6
`define SETUP_RATE_HI 7
`define SETUP_SLEEP_BIT 8
`define SETUP_LATCH_BIT 9
`define SETUP_LEVEL_BIT 10
`define SETUP_FAULT_LO 11
`define SETUP_FAULT_HI 12
`define SETUP_SHOT_BIT 15

// Reset values and masks
`define SETUP_RESET 16'h40a0
`define SETUP_WR_MASK 16'h9fc0
`define SETUP_FIXED 16'h4000
`define LOWER_RESET 16'h4b00
`define UPPER_RESET 16'h5000
`define RESULT_RESET 16'h0000

// Conversion timing
`define CLK_MHZ 200
`define RATE_BASE_MS 125
`define TICKS_4S 6'd32
`define TICKS_1S 6'd8
`define TICKS_250MS 6'd2
`define TICKS_125MS 6'd1

`endif

// ==== core/temp_sensor_register_bank.v ====
// Register bank and threshold flag logic of a digital temperature sensor.
// Assumes a serial front end that hands over pointer writes and data bytes,
// and an analog converter that answers a start pulse with a 12-bit result.
//
// Contract
// (R1) Eight-bit pointer, two low bits writable
// (R2) Pointer selects result, setup, lower, upper
// (R3) Host loads pointer before data access
// (R4) Result read-only; other three read/write
// (R5) Sixteen-bit setup moves MSB byte first
// (R6) Setup bits 0-4, 13-14 ignore writes
// (R7) Host keeps width select bit cleared
// (R8) Flag drops after enough high faults
// (R9) Flag rises after enough low faults
// (R10) Level select inverts flag sense
// (R11) Comparator mode: flag equals alert pin
// (R12) Result changes only on conversion complete
// (R13) Rate field sets period, default 250 ms
// (R14) Fault field needs 1, 2, 4, 6
// (R15) Level select: alert low or high active
// (R16) Sleep stops conversions, bus stays alive
// (R17) Latch style: comparator or interrupt
// (R18) Consecutive fault counter per completed conversion
`timescale 1ns/10ps
`default_nettype none
`include "temp_sensor_defs.vh"

module temp_sensor_register_bank #(
	parameter [31:0] TICK_CYCLES = `RATE_BASE_MS * 1000 * `CLK_MHZ
) (
	input wire core_clk,
	input wire rst_n,
	input wire frame_start,
	input wire pointer_wr,
	input wire byte_wr,
	input wire [7:0] wr_byte,
	input wire byte_rd,
	output reg [7:0] rd_byte,
	output wire [7:0] pointer_value,
	output reg conv_start,
	input wire conv_done,
	input wire [11:0] conv_data,
	output wire alert_o,
	output wire alert_oe
);

	reg [1:0] pointer_reg;
	reg [15:0] setup_reg;
	reg [15:0] lower_reg;
	reg [15:0] upper_reg;
	reg [15:0] result_reg;
	reg [7:0] hold_reg;
	reg phase_reg;
	reg busy_reg;
	reg shot_reg;
	reg kick_reg;
	reg over_reg;
	reg int_reg;
	reg [2:0] fault_cnt_reg;
	reg [15:0] rd_word;
	reg [5:0] period_ticks;
	reg [2:0] fault_need;
	wire sleep_request;
	wire latch_style_select;
	wire active_level_select;
	wire period_due;
	wire [15:0] wr_word;
	wire wr_commit;
	wire setup_wr;
	wire shot_wr;
	wire take_result;
	wire high_hit;
	wire low_hit;
	wire pending_hit;
	wire fault_full;
	wire alert_active;
	wire threshold_flag;
	wire alert_level;

	assign sleep_request = setup_reg[`SETUP_SLEEP_BIT];
	assign latch_style_select = setup_reg[`SETUP_LATCH_BIT];
	assign active_level_select = setup_reg[`SETUP_LEVEL_BIT];

	// Upper pointer bits are constant zero
	assign pointer_value = {6'h00, pointer_reg}; // (R1)

	// Pointer write also restarts byte pairing
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_reg <= `SEL_RESULT;
		end else if (pointer_wr) begin
			pointer_reg <= wr_byte[1:0]; // (R1)
		end
	end

	// Byte phase: first byte is MSB, second is LSB
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 1'b0;
			hold_reg <= 8'h00;
		end else if (frame_start || pointer_wr) begin
			phase_reg <= 1'b0;
		end else if (byte_wr || byte_rd) begin
			phase_reg <= ~phase_reg; // (R5)
			if (byte_wr && !phase_reg) begin
				hold_reg <= wr_byte;
			end
		end
	end

	assign wr_word = {hold_reg, wr_byte};
	assign wr_commit = byte_wr && phase_reg && !frame_start && !pointer_wr; // (R5)
	assign setup_wr = wr_commit && (pointer_reg == `SEL_SETUP); // (R3)
	assign shot_wr = setup_wr && wr_word[`SETUP_SHOT_BIT] && sleep_request;

	// Read mux, pointer steers which register answers
	always @* begin
		case (pointer_reg) // (R2)
			`SEL_RESULT: rd_word = result_reg;
			`SEL_SETUP: rd_word = {shot_reg, setup_reg[14:6], threshold_flag, 5'h00};
			`SEL_LOWER: rd_word = lower_reg;
			`SEL_UPPER: rd_word = upper_reg;
			default: rd_word = 16'h0000;
		endcase
	end

	// Read data held in a flop until the next read strobe
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte <= 8'h00;
		end else if (byte_rd) begin
			rd_byte <= phase_reg ? rd_word[7:0] : rd_word[15:8]; // (R5)
		end
	end

	// Threshold and setup writes; result has no write path
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_reg <= `SETUP_RESET;
			lower_reg <= `LOWER_RESET;
			upper_reg <= `UPPER_RESET;
		end else if (wr_commit) begin
			case (pointer_reg) // (R4)
				`SEL_SETUP: setup_reg <= (wr_word & `SETUP_WR_MASK) | `SETUP_FIXED; // (R6)
				`SEL_LOWER: lower_reg <= {wr_word[15:4], 4'h0};
				`SEL_UPPER: upper_reg <= {wr_word[15:4], 4'h0};
				default: setup_reg <= setup_reg;
			endcase
		end
	end

	// Rate field to period in base ticks
	always @* begin
		case (setup_reg[`SETUP_RATE_HI:`SETUP_RATE_LO]) // (R13)
			2'b00: period_ticks = `TICKS_4S;
			2'b01: period_ticks = `TICKS_1S;
			2'b10: period_ticks = `TICKS_250MS;
			2'b11: period_ticks = `TICKS_125MS;
			default: period_ticks = `TICKS_250MS;
		endcase
	end

	// Fault field to required consecutive count
	always @* begin
		case (setup_reg[`SETUP_FAULT_HI:`SETUP_FAULT_LO]) // (R14)
			2'b00: fault_need = 3'd1;
			2'b01: fault_need = 3'd2;
			2'b10: fault_need = 3'd4;
			2'b11: fault_need = 3'd6;
			default: fault_need = 3'd1;
		endcase
	end

	conversion_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hold(sleep_request),
		.period_ticks(period_ticks),
		.period_due(period_due)
	);

	// Conversion sequencing; kick gives one start right after reset or wake-up,
	// later starts wait for the period so the rate field really paces them
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_start <= 1'b0;
			busy_reg <= 1'b0;
			shot_reg <= 1'b0;
			kick_reg <= 1'b1;
		end else begin
			conv_start <= 1'b0;
			if (shot_wr && !busy_reg) begin
				shot_reg <= 1'b1;
				busy_reg <= 1'b1;
				conv_start <= 1'b1;
			end else if (sleep_request && !shot_reg) begin
				busy_reg <= 1'b0; // (R16)
				kick_reg <= 1'b1;
			end else if (conv_done && busy_reg) begin
				busy_reg <= 1'b0;
				shot_reg <= 1'b0;
			end else if (!busy_reg && (period_due || kick_reg)) begin
				if (!sleep_request) begin
					busy_reg <= 1'b1;
					conv_start <= 1'b1; // (R13)
					kick_reg <= 1'b0;
				end
			end
		end
	end

	// Results arriving in sleep (outside a single shot) are dropped
	assign take_result = conv_done && busy_reg && (!sleep_request || shot_reg);

	// Result only moves on a finished conversion
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= `RESULT_RESET;
		end else if (take_result) begin
			result_reg <= {conv_data, 4'h0}; // (R12)
		end
	end

	// Signed compares on the 12-bit temperature codes
	assign high_hit = $signed(conv_data) >= $signed(upper_reg[15:4]);
	assign low_hit = $signed(conv_data) <= $signed(lower_reg[15:4]);
	assign pending_hit = over_reg ? low_hit : high_hit;
	assign fault_full = (fault_cnt_reg + 3'd1) >= fault_need;

	// Fault counter restarts on any miss of the pending condition
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_cnt_reg <= 3'd0;
			over_reg <= 1'b0;
		end else if (take_result) begin
			if (!pending_hit) begin
				fault_cnt_reg <= 3'd0; // (R18)
			end else if (fault_full) begin
				fault_cnt_reg <= 3'd0;
				over_reg <= ~over_reg; // (R8) (R9)
			end else begin
				fault_cnt_reg <= fault_cnt_reg + 3'd1; // (R18)
			end
		end
	end

	// Interrupt style: event sets, any read or sleep clears; set wins
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_reg <= 1'b0;
		end else if (take_result && pending_hit && fault_full) begin
			int_reg <= 1'b1; // (R17)
		end else if (byte_rd || sleep_request) begin
			int_reg <= 1'b0;
		end
	end

	assign alert_active = latch_style_select ? int_reg : over_reg; // (R17)
	// Flag tracks the over state, sense set by level select
	assign threshold_flag = active_level_select ? over_reg : ~over_reg; // (R8) (R10)
	assign alert_level = active_level_select ? alert_active : ~alert_active; // (R15) (R11)

	// Open-drain pin: pull low only, pull-up gives the high level
	assign alert_o = 1'b0;
	assign alert_oe = ~alert_level;

endmodule
`default_nettype wire

// ==== testbench/conv_model.sv ====
// Converter model: answers each start with one done pulse and a code.
// Assumes the bench supplies the temperature code to report.
`timescale 1ns/10ps
`default_nettype none
module conv_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic [11:0] temp,
	output logic conv_done,
	output logic [11:0] conv_data
);
	int busy;
	logic slow;
	// Prompt and slow answers alternate; data toggles outside the pulse
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 0;
			slow <= 1'h0;
			conv_done <= 1'h0;
			conv_data <= 12'h000;
		end else begin
			conv_done <= 1'h0;
			conv_data <= ~conv_data;
			if (conv_start) begin
				busy <= slow ? 7 : 2;
				slow <= !slow;
			end else if (busy == 1) begin
				conv_done <= 1'h1;
				conv_data <= temp;
				busy <= 0;
			end else if (busy > 1) begin
				busy <= busy - 1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/temp_bank_checker.sv ====
// Port checker for the temperature register bank.
// Assumes one clock and an async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module temp_bank_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pointer_wr,
	input wire logic byte_wr,
	input wire logic [7:0] wr_byte,
	input wire logic byte_rd,
	input wire logic [7:0] rd_byte,
	input wire logic [7:0] pointer_value,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic alert_o,
	input wire logic alert_oe
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Pointer width and loading
	ptr_top_a: assert property (pointer_value[7:2] == 6'h00) else $error("pointer top bits");
	ptr_load_a: assert property (pointer_wr |=> pointer_value[1:0] == $past(wr_byte[1:0])) else $error("ptr load");
	ptr_hold_a: assert property (!pointer_wr |=> $stable(pointer_value)) else $error("pointer moved");
	// Read byte moves only on a read
	rd_hold_a: assert property ($changed(rd_byte) |-> $past(byte_rd)) else $error("read byte moved");
	// Pin moves only after a conversion, write or read
	pin_cause_a: assert property ($changed(alert_oe) |->
		$past(conv_done || byte_wr || byte_rd) || $past(byte_wr, 2)) else $error("pin moved");
	pin_data_a: assert property (alert_o == 1'h0) else $error("pin driven high");
	// Starts are lone pulses, the first right after reset
	start_gap_a: assert property (conv_start |=> !conv_start [*8]) else $error("start too soon");
	first_conv_a: assert property ($rose(rst_n) |-> ##[0:2] conv_start) else $error("no first start");
	done_c: cover property (conv_done);
	write_c: cover property (pointer_wr ##1 byte_wr);
	pin_c: cover property ($rose(alert_oe));
endmodule
bind temp_sensor_register_bank temp_bank_checker chk_i (.core_clk(core_clk), .rst_n(rst_n),
	.pointer_wr(pointer_wr), .byte_wr(byte_wr), .wr_byte(wr_byte), .byte_rd(byte_rd), .rd_byte(rd_byte),
	.pointer_value(pointer_value), .conv_start(conv_start), .conv_done(conv_done), .alert_o(alert_o),
	.alert_oe(alert_oe));
`default_nettype wire

// ==== testbench/test_temp_sensor_register_bank.sv ====
// Self-checking bench of the register bank with a converter model.
// Assumes a short conversion tick so each base tick spans 60 clocks.
`timescale 1ns/10ps
`default_nettype none
`include "temp_sensor_defs.vh"
module test_temp_sensor_register_bank;
	logic core_clk = 1'h0, rst_n = 1'h0, frame_start = 1'h0, pointer_wr = 1'h0, byte_wr = 1'h0, byte_rd = 1'h0;
	logic [7:0] wr_byte = 8'h00;
	logic [11:0] temp = 12'h280;
	logic [31:0] lfsr = 32'h0000_7062;
	logic [15:0] setup_m = 16'h4080, res_m = `RESULT_RESET, lo_m = `LOWER_RESET, hi_m = `UPPER_RESET, v;
	logic over = 1'h0, intr = 1'h0;
	int fails = 0, n_tests = 0, cnt = 0, ndone = 0, starts = 0;
	wire [7:0] rd_byte, pointer_value;
	wire [11:0] conv_data;
	wire conv_start, conv_done, alert_o, alert_oe;
	temp_sensor_register_bank #(.TICK_CYCLES(32'h0000_003c)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.frame_start(frame_start), .pointer_wr(pointer_wr), .byte_wr(byte_wr), .wr_byte(wr_byte),
		.byte_rd(byte_rd), .rd_byte(rd_byte), .pointer_value(pointer_value), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data), .alert_o(alert_o), .alert_oe(alert_oe));
	conv_model conv_i (.core_clk(core_clk), .rst_n(rst_n), .conv_start(conv_start), .temp(temp),
		.conv_done(conv_done), .conv_data(conv_data));
	initial forever #2.5 core_clk = !core_clk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int need(input logic [1:0] f);
		need = (f == 2'h0) ? 1 : (f == 2'h1) ? 2 : (f == 2'h2) ? 4 : 6;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Pointer load with junk in the unused top bits
	task automatic sp(input logic [1:0] sel);
		lfsr = nx(lfsr);
		@(posedge core_clk);
		pointer_wr <= 1'h1;
		wr_byte <= {lfsr[7:2], sel};
		@(posedge core_clk);
		pointer_wr <= 1'h0;
		#1 chk({8'h00, pointer_value}, {14'h0000, sel});
	endtask
	// Two data bytes, MSB first, strobe held across both
	task automatic wb(input logic [15:0] w);
		@(posedge core_clk);
		byte_wr <= 1'h1;
		wr_byte <= w[15:8];
		@(posedge core_clk);
		wr_byte <= w[7:0];
		@(posedge core_clk);
		byte_wr <= 1'h0;
	endtask
	task automatic wr(input logic [1:0] sel, input logic [15:0] w);
		sp(sel);
		wb(w);
	endtask
	task automatic rd(input logic [1:0] sel, output logic [15:0] r);
		sp(sel);
		@(posedge core_clk);
		byte_rd <= 1'h1;
		@(posedge core_clk);
		#1 r[15:8] = rd_byte;
		@(posedge core_clk);
		byte_rd <= 1'h0;
		#1 r[7:0] = rd_byte;
	endtask
	// Reference flag, advanced on every completed conversion
	always @(posedge core_clk) begin
		if (byte_rd === 1'h1)
			intr = 1'h0;
		if (conv_done === 1'h1) begin
			res_m = {conv_data, 4'h0};
			if (over ? $signed(res_m) <= $signed(lo_m) : $signed(res_m) >= $signed(hi_m))
				cnt = cnt + 1;
			else
				cnt = 0;
			if (cnt >= need(setup_m[12:11])) begin
				over = !over;
				intr = 1'h1;
				cnt = 0;
			end
			ndone++;
		end
	end
	// Counted wait; a lost converter shows as a counted failure, not a hang
	task automatic wc(input int n);
		int goal, k;
		goal = ndone + n;
		k = 0;
		while (ndone < goal && k < 2000) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= 2000) fails++;
		repeat (2) @(posedge core_clk);
	endtask
	// Pin first: in interrupt style any read clears it
	task automatic look;
		#1 chk({15'h0000, alert_oe}, {15'h0000, (setup_m[9] ? intr : over) ^ setup_m[10]});
		rd(2'h1, v);
		chk(v, setup_m | {10'h000, over ^ !setup_m[10], 5'h00});
		chk({15'h0000, alert_oe}, {15'h0000, (setup_m[9] ? intr : over) ^ setup_m[10]});
		rd(2'h0, v);
		chk(v, res_m);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'h1;
		rd(2'h1, v);
		chk(v, `SETUP_RESET);
		rd(2'h2, v);
		chk(v, lo_m);
		lfsr = nx(lfsr);
		lo_m = 16'h2000;
		hi_m = 16'h3000;
		wr(2'h2, {12'h200, lfsr[3:0]});
		wr(2'h3, {12'h300, lfsr[7:4]});
		wr(2'h0, lfsr[31:16]);
		// Stray byte then a new frame: pairing restarts at the MSB
		sp(2'h3);
		@(posedge core_clk);
		byte_wr <= 1'h1;
		wr_byte <= {1'h1, lfsr[14:8]};
		@(posedge core_clk);
		byte_wr <= 1'h0;
		frame_start <= 1'h1;
		@(posedge core_clk);
		frame_start <= 1'h0;
		wb({12'h300, lfsr[11:8]});
		rd(2'h3, v);
		chk(v, hi_m);
		rd(2'h2, v);
		chk(v, lo_m);
		for (int f = 0; f < 4; f++) begin
			lfsr = nx(lfsr);
			setup_m = 16'h40c0 | {3'h0, f[1:0], f[0], 10'h000};
			wr(2'h1, setup_m | (lfsr[15:0] & 16'h600f));
			temp <= 12'h280;
			wc(1);
			look;
			temp <= 12'h300 + {8'h00, lfsr[19:16]};
			wc(need(f[1:0]) - 1);
			look;
			wc(1);
			look;
			temp <= 12'h200 - {8'h00, lfsr[23:20]};
			wc(need(f[1:0]));
			look;
		end
		wr(2'h1, setup_m | 16'h0100);
		repeat (200) begin
			@(posedge core_clk);
			if (conv_start === 1'h1) starts++;
		end
		chk(starts[15:0], 16'h0000);
		// Single shot while asleep: one conversion, then asleep again
		wr(2'h1, setup_m | 16'h8100);
		wc(1);
		rd(2'h1, v);
		chk(v, setup_m | 16'h0100 | {10'h000, over ^ !setup_m[10], 5'h00});
		rd(2'h0, v);
		chk(v, res_m);
		wr(2'h1, setup_m);
		wc(1);
		look;
		// Interrupt style: each flip sets the pin, any read clears it
		setup_m = 16'h42c0;
		wr(2'h1, setup_m);
		temp <= 12'h300;
		wc(1);
		look;
		temp <= 12'h180;
		wc(1);
		look;
		final_report;
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		fails++;
		final_report;
	end
endmodule
`default_nettype wire
